// File: design/crgi_pkg.sv
/*
  Constants shared by both ends of the converter start-up link: serial
  commands, configuration bit positions, gain format, timing counts and
  the controller's register map.
  Assumes a single 200 MHz system clock on both ends.
*/
`default_nettype none
package crgi_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ       = 200_000_000;
  localparam int OSC_WAIT_MS  = 500;
  localparam int OSC_WAIT_CYC = OSC_WAIT_MS * (CLK_HZ / 1000);
  localparam int SCLK_HALF    = 10;
  localparam int RST_CYC      = 8;
  localparam int SYNC_ONES    = 8;
  localparam int SYNC_WORDS   = 4;
  // ----------------------------------------------------------------
  // Serial commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_CFG  = 8'h03;
  localparam logic [7:0] CMD_RD_CFG  = 8'h0B;
  localparam logic [7:0] CMD_WR_GAIN = 8'h02;
  localparam logic [7:0] CMD_RD_GAIN = 8'h0A;
  localparam logic [7:0] CMD_CONV    = 8'hC0;
  localparam logic [7:0] SYNC1       = 8'hFF;
  localparam logic [7:0] SYNC0       = 8'hFE;
  localparam logic [7:0] CONV_EXIT   = 8'hFF;
  localparam logic [7:0] CONV_HDR    = 8'h00;
  // ----------------------------------------------------------------
  // Device words
  // ----------------------------------------------------------------
  typedef logic [23:0] crgi_word_t;
  localparam int         CFG_RS       = 7;
  localparam int         CFG_RV       = 6;
  localparam int         GAIN_FRAC    = 22;
  localparam crgi_word_t CFG_DEFAULT  = 24'h000000;
  localparam crgi_word_t CFG_RS_WORD  = 24'h000080;
  localparam crgi_word_t GAIN_DEFAULT = 24'h400000;
  localparam crgi_word_t GAIN_MIN     = 24'h266666;
  localparam crgi_word_t WORD_MAX     = 24'hFFFFFF;
  // ----------------------------------------------------------------
  // Controller register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_GAIN     = 8'h10;
  localparam logic [7:0] REG_DATA     = 8'h14;
  localparam int CTL_INIT  = 0;
  localparam int CTL_CMOS  = 1;
  localparam int CTL_GAIN  = 2;
  localparam int CTL_CONV  = 3;
  localparam int CTL_FETCH = 4;
  localparam int ST_BUSY   = 0;
  localparam int ST_INIT   = 1;
  localparam int ST_CONV   = 2;
  localparam int IRQ_INIT  = 0;
  localparam int IRQ_DATA  = 1;
endpackage
`default_nettype wire

// File: design/crgi_link_if.sv
/*
  Four-wire serial link between the controller and the converter core.
  Assumes the serial data output is pulled high while nobody drives it.
*/
`default_nettype none
interface crgi_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // Resolved level of the serial data output wire.
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (input cs_n, input sclk, input sdi, output sdo, output sdo_oe);
  modport hst (output cs_n, output sclk, output sdi, input sdo_line);
endinterface
`default_nettype wire

// File: design/crgi_dev.sv
/*
  Converter core end: serial port, configuration with software reset,
  digital gain scaling and conversion ready flag.
  Assumes link pins synchronous to clk_sys_in and a serial clock half
  period of at least three system clocks.
*/
`default_nettype none
// Behaviour
// - Gain 0.6 to under four, scales span.
// - Gain near one gives nominal ranges.
// - Gain shifted left doubles effective gain.
// - Host avoids gain below 0.6.
// - Host waits 500 ms for crystal start.
// - CMOS clock lets host skip that wait.
// - Host synchronises port before any command.
// - Host writes one to reset request.
// - Device raises reset done; host polls it.
// - Host then writes zero to configuration.
// - During reset request all registers default.
// - After request clears, wait for command.
// - Ready flag on data output; host reads.
// - Chip select high: output off, clock ignored.
module crgi_dev
  (
    // Clock and reset.
    input  wire logic               clk_sys_in,
    input  wire logic               arst_n_in,
    // Serial link.
    crgi_link_if.dev                link,
    // Raw samples from the modulator filter.
    input  wire crgi_pkg::crgi_word_t sample_in,
    input  wire logic               sample_valid_in,
    // Status towards the core.
    output logic [23:0]             gain_out,
    output logic [23:0]             data_out,
    output logic                    converting_out,
    output logic                    reset_active_out
  );
  import crgi_pkg::*;

  typedef enum logic [1:0]
  {
    D_CMD  = 2'b00,
    D_WR   = 2'b01,
    D_RD   = 2'b11,
    D_CONV = 2'b10
  } crgi_dst_e;

  crgi_dst_e   state_reg;
  logic        sclk_q_reg;
  logic [4:0]  bit_cnt_reg;
  logic [23:0] rx_reg;
  logic [23:0] tx_reg;
  logic [7:0]  cmd_reg;
  logic [3:0]  ones_reg;
  logic        synced_reg;
  logic [23:0] cfg_reg;
  logic        rv_reg;
  logic [2:0]  rst_cnt_reg;
  logic [23:0] gain_reg;
  logic [23:0] conv_reg;
  logic        ready_reg;
  logic        conv_mode_reg;
  logic        sdo_reg;
  logic        sdo_oe_reg;

  logic        rise;
  logic        fall;
  logic        byte_st;
  logic        last_bit;
  logic        byte_done;
  logic        word_done;
  logic [23:0] rx_next;
  logic [7:0]  byte_in;
  logic        rs;
  logic        go_rd;
  logic [23:0] rd_word;
  logic [47:0] product;
  logic [23:0] scaled;

  // ----------------------------------------------------------------
  // Serial edges and bit counting
  // ----------------------------------------------------------------
  assign rise      = !link.cs_n && link.sclk && !sclk_q_reg;
  assign fall      = !link.cs_n && !link.sclk && sclk_q_reg;
  assign byte_st   = (state_reg == D_CMD) || (state_reg == D_CONV);
  assign last_bit  = byte_st ? (bit_cnt_reg == 5'd7) : (bit_cnt_reg == 5'd23);
  assign byte_done = rise && byte_st && last_bit;
  assign word_done = rise && !byte_st && last_bit;
  assign rx_next   = {rx_reg[22:0], link.sdi};
  assign byte_in   = rx_next[7:0];
  assign rs        = cfg_reg[CFG_RS];

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      sclk_q_reg <= 1'b0;
    else
      sclk_q_reg <= link.sclk;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      bit_cnt_reg <= 5'd0;
    else if (link.cs_n)
      bit_cnt_reg <= 5'd0;
    else if (rise)
      bit_cnt_reg <= last_bit ? 5'd0 : bit_cnt_reg + 5'd1;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rx_reg <= 24'h000000;
    else if (rise)
      rx_reg <= rx_next;
  end

  // ----------------------------------------------------------------
  // Port synchronisation
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ones_reg   <= 4'd0;
      synced_reg <= 1'b0;
    end
    else if (byte_done && state_reg == D_CMD)
    begin
      if (byte_in == SYNC1)
        ones_reg <= (ones_reg == 4'hF) ? ones_reg : ones_reg + 4'd1;
      else
        ones_reg <= 4'd0;
      if (byte_in == SYNC0 && ones_reg >= 4'(SYNC_ONES))
        synced_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Command decode and read source
  // ----------------------------------------------------------------
  always_comb
  begin
    go_rd   = 1'b0;
    rd_word = conv_reg;
    if (byte_done && state_reg == D_CMD && synced_reg)
    begin
      if (byte_in == CMD_RD_CFG)
      begin
        go_rd   = 1'b1;
        rd_word = cfg_reg | {17'h00000, rv_reg, 6'h00};
      end
      else if (byte_in == CMD_RD_GAIN)
      begin
        go_rd   = 1'b1;
        rd_word = gain_reg;
      end
    end
    else if (byte_done && state_reg == D_CONV)
      go_rd = (byte_in != CONV_EXIT) && ready_reg;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg     <= D_CMD;
      cmd_reg       <= 8'h00;
      conv_mode_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        D_CMD:
        begin
          if (go_rd)
            state_reg <= D_RD;
          else if (byte_done && synced_reg)
          begin
            cmd_reg <= byte_in;
            if (byte_in == CMD_WR_CFG || byte_in == CMD_WR_GAIN)
              state_reg <= D_WR;
            else if (byte_in == CMD_CONV && !rs)
            begin
              conv_mode_reg <= 1'b1;
              state_reg     <= D_CONV;
            end
          end
        end
        D_WR:
        begin
          if (word_done)
            state_reg <= D_CMD;
        end
        D_RD:
        begin
          if (word_done)
            state_reg <= conv_mode_reg ? D_CONV : D_CMD;
        end
        D_CONV:
        begin
          if (go_rd)
            state_reg <= D_RD;
          else if (byte_done && byte_in == CONV_EXIT)
          begin
            conv_mode_reg <= 1'b0;
            state_reg     <= D_CMD;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration, software reset and gain
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cfg_reg <= CFG_DEFAULT;
    else if (word_done && state_reg == D_WR && cmd_reg == CMD_WR_CFG)
    begin
      if (rx_next[CFG_RS])
        cfg_reg <= CFG_DEFAULT | CFG_RS_WORD;
      else
        cfg_reg <= rx_next & ~(CFG_RS_WORD >> 1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_cnt_reg <= 3'd0;
      rv_reg      <= 1'b0;
    end
    else if (!rs)
    begin
      rst_cnt_reg <= 3'd0;
      rv_reg      <= 1'b0;
    end
    else if (rst_cnt_reg != 3'(RST_CYC - 1))
      rst_cnt_reg <= rst_cnt_reg + 3'd1;
    else
      rv_reg <= 1'b1;
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      gain_reg <= GAIN_DEFAULT;
    else if (rs)
      gain_reg <= GAIN_DEFAULT;
    else if (word_done && state_reg == D_WR && cmd_reg == CMD_WR_GAIN)
      gain_reg <= (rx_next < GAIN_MIN) ? GAIN_MIN : rx_next;
  end

  // ----------------------------------------------------------------
  // Gain scaling and data ready
  // ----------------------------------------------------------------
  assign product = {24'h000000, sample_in} * {24'h000000, gain_reg};
  assign scaled  = (product[47:46] != 2'b00) ? WORD_MAX : product[45:GAIN_FRAC];

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      conv_reg  <= 24'h000000;
      ready_reg <= 1'b0;
    end
    else if (rs)
    begin
      conv_reg  <= 24'h000000;
      ready_reg <= 1'b0;
    end
    else
    begin
      if (go_rd && state_reg == D_CONV)
        ready_reg <= 1'b0;
      if (sample_valid_in && conv_mode_reg)
      begin
        conv_reg  <= scaled;
        ready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial data output
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      tx_reg <= 24'h000000;
    else if (go_rd)
      tx_reg <= rd_word;
    else if (fall && state_reg == D_RD)
      tx_reg <= {tx_reg[22:0], 1'b0};
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sdo_reg    <= 1'b1;
      sdo_oe_reg <= 1'b0;
    end
    else
    begin
      sdo_oe_reg <= !link.cs_n;
      if (link.cs_n)
        sdo_reg <= 1'b1;
      else if (state_reg == D_RD)
      begin
        if (fall)
          sdo_reg <= tx_reg[23];
      end
      else if (link.sclk)
        sdo_reg <= sdo_reg;  // Output only moves while the serial clock is low.
      else if (state_reg == D_CONV)
        sdo_reg <= !ready_reg;
      else
        sdo_reg <= 1'b1;
    end
  end

  assign link.sdo         = sdo_reg;
  assign link.sdo_oe      = sdo_oe_reg;
  assign gain_out         = gain_reg;
  assign data_out         = conv_reg;
  assign converting_out   = conv_mode_reg;
  assign reset_active_out = rs;
endmodule
`default_nettype wire

// File: design/crgi_host.sv
/*
  Controller end: runs the converter start-up sequence, writes the gain,
  starts conversions and fetches results on software's orders.
  Assumes a converter core on the far end of the link that honours the
  serial commands of crgi_pkg.
*/
`default_nettype none
module crgi_host
  #(
    parameter int OSC_CYC = crgi_pkg::OSC_WAIT_CYC
  )
  (
    // Clock and reset.
    input  wire logic        clk_sys_in,
    input  wire logic        arst_n_in,
    // Serial link.
    crgi_link_if.hst         link,
    // Register port.
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    output logic             irq_out
  );
  import crgi_pkg::*;

  typedef enum logic [3:0]
  {
    H_IDLE  = 4'b0000,
    H_OSC   = 4'b0001,
    H_SYNC  = 4'b0011,
    H_SETRS = 4'b0010,
    H_POLL  = 4'b0110,
    H_CLRRS = 4'b0111,
    H_READY = 4'b0101,
    H_GAIN  = 4'b0100,
    H_CONV  = 4'b1100,
    H_FETCH = 4'b1101
  } crgi_hst_e;

  crgi_hst_e   state_reg;
  logic [26:0] osc_cnt_reg;
  logic [1:0]  sync_cnt_reg;
  logic        issued_reg;
  logic        cmos_reg;
  logic        init_reg;
  logic        conv_on_reg;
  logic [23:0] gain_reg;
  logic [23:0] data_reg;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_mask_reg;
  logic        busy_reg;
  logic        wait_reg;
  logic        phase_reg;
  logic [3:0]  div_reg;
  logic [5:0]  left_reg;
  logic [31:0] sh_reg;
  logic [31:0] rx_reg;
  logic        done_reg;
  logic        cs_n_reg;
  logic        sclk_reg;
  logic        sdi_reg;

  logic        fr_need;
  logic        fr_start;
  logic        fr_wait;
  logic [5:0]  fr_len;
  logic [31:0] fr_word;
  logic [31:0] ctl;
  logic [1:0]  irq_set;

  assign ctl = (wr_in && addr_in == REG_CTRL) ? wdata_in : 32'h00000000;

  // ----------------------------------------------------------------
  // Frame contents per step
  // ----------------------------------------------------------------
  always_comb
  begin
    fr_need = 1'b1;
    fr_wait = 1'b0;
    fr_len  = 6'd32;
    fr_word = 32'h00000000;
    unique case (state_reg)
      H_SYNC:  fr_word = (sync_cnt_reg == 2'(SYNC_WORDS - 1)) ? {{3{SYNC1}}, SYNC0} : {4{SYNC1}};
      H_SETRS: fr_word = {CMD_WR_CFG, CFG_RS_WORD};
      H_POLL:  fr_word = {CMD_RD_CFG, 24'h000000};
      H_CLRRS: fr_word = {CMD_WR_CFG, CFG_DEFAULT};
      H_GAIN:  fr_word = {CMD_WR_GAIN, gain_reg};
      H_CONV:
      begin
        fr_word = {CMD_CONV, 24'h000000};
        fr_len  = 6'd8;
      end
      H_FETCH:
      begin
        fr_word = {CONV_HDR, 24'h000000};
        fr_wait = 1'b1;
      end
      default: fr_need = 1'b0;
    endcase
  end

  assign fr_start = fr_need && !issued_reg && !busy_reg && !done_reg;

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      busy_reg  <= 1'b0;
      wait_reg  <= 1'b0;
      phase_reg <= 1'b0;
      div_reg   <= 4'd0;
      left_reg  <= 6'd0;
      sh_reg    <= 32'h00000000;
      rx_reg    <= 32'h00000000;
      done_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
      sclk_reg  <= 1'b0;
      sdi_reg   <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (fr_start)
      begin
        busy_reg  <= 1'b1;
        wait_reg  <= fr_wait;
        phase_reg <= 1'b0;
        div_reg   <= 4'd0;
        left_reg  <= fr_len;
        sh_reg    <= fr_word;
        sdi_reg   <= fr_word[31];
        cs_n_reg  <= 1'b0;
        sclk_reg  <= 1'b0;
      end
      else if (busy_reg && wait_reg)
        wait_reg <= link.sdo_line;
      else if (busy_reg && div_reg != 4'(SCLK_HALF - 1))
        div_reg <= div_reg + 4'd1;
      else if (busy_reg)
      begin
        div_reg   <= 4'd0;
        phase_reg <= !phase_reg;
        sclk_reg  <= !phase_reg;
        if (!phase_reg)
          rx_reg <= {rx_reg[30:0], link.sdo_line};
        else
        begin
          sh_reg   <= {sh_reg[30:0], 1'b0};
          sdi_reg  <= sh_reg[30];
          left_reg <= left_reg - 6'd1;
          if (left_reg == 6'd1)
          begin
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            cs_n_reg <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Start-up and command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg    <= H_IDLE;
      osc_cnt_reg  <= 27'd0;
      sync_cnt_reg <= 2'd0;
      issued_reg   <= 1'b0;
      init_reg     <= 1'b0;
      conv_on_reg  <= 1'b0;
      data_reg     <= 24'h000000;
    end
    else
    begin
      if (fr_start)
        issued_reg <= 1'b1;
      else if (done_reg)
        issued_reg <= 1'b0;
      unique case (state_reg)
        H_IDLE, H_READY:
        begin
          if (ctl[CTL_INIT])
          begin
            osc_cnt_reg <= 27'd0;
            init_reg    <= 1'b0;
            conv_on_reg <= 1'b0;
            state_reg   <= H_OSC;
          end
          else if (state_reg == H_READY && ctl[CTL_GAIN] && !conv_on_reg)
            state_reg <= H_GAIN;
          else if (state_reg == H_READY && ctl[CTL_CONV] && !conv_on_reg)
            state_reg <= H_CONV;
          else if (state_reg == H_READY && ctl[CTL_FETCH] && conv_on_reg)
            state_reg <= H_FETCH;
        end
        H_OSC:
        begin
          if (cmos_reg || osc_cnt_reg == 27'(OSC_CYC - 1))
          begin
            sync_cnt_reg <= 2'd0;
            state_reg    <= H_SYNC;
          end
          else
            osc_cnt_reg <= osc_cnt_reg + 27'd1;
        end
        H_SYNC:
        begin
          if (done_reg && sync_cnt_reg == 2'(SYNC_WORDS - 1))
            state_reg <= H_SETRS;
          else if (done_reg)
            sync_cnt_reg <= sync_cnt_reg + 2'd1;
        end
        H_SETRS:
        begin
          if (done_reg)
            state_reg <= H_POLL;
        end
        H_POLL:
        begin
          if (done_reg && rx_reg[CFG_RV])
            state_reg <= H_CLRRS;
        end
        H_CLRRS:
        begin
          if (done_reg)
          begin
            init_reg  <= 1'b1;
            state_reg <= H_READY;
          end
        end
        H_GAIN:
        begin
          if (done_reg)
            state_reg <= H_READY;
        end
        H_CONV:
        begin
          if (done_reg)
          begin
            conv_on_reg <= 1'b1;
            state_reg   <= H_READY;
          end
        end
        H_FETCH:
        begin
          if (done_reg)
          begin
            data_reg  <= rx_reg[23:0];
            state_reg <= H_READY;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Software registers and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cmos_reg     <= 1'b0;
      gain_reg     <= GAIN_DEFAULT;
      irq_mask_reg <= 2'b00;
    end
    else if (wr_in)
    begin
      if (addr_in == REG_CTRL)
        cmos_reg <= wdata_in[CTL_CMOS];
      if (addr_in == REG_GAIN)
        gain_reg <= (wdata_in[23:0] < GAIN_MIN) ? GAIN_MIN : wdata_in[23:0];
      if (addr_in == REG_IRQ_MASK)
        irq_mask_reg <= wdata_in[1:0];
    end
  end

  assign irq_set[IRQ_INIT] = done_reg && state_reg == H_CLRRS;
  assign irq_set[IRQ_DATA] = done_reg && state_reg == H_FETCH;

  always_ff @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_stat_reg <= 2'b00;
      irq_out      <= 1'b0;
      rdata_out    <= 32'h00000000;
    end
    else
    begin
      if (wr_in && addr_in == REG_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~wdata_in[1:0]) | irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
      irq_out   <= |(irq_stat_reg & irq_mask_reg);
      rdata_out <= 32'h00000000;
      if (rd_in)
      begin
        unique case (addr_in)
          REG_CTRL:     rdata_out <= {30'h00000000, cmos_reg, 1'b0};
          REG_STATUS:   rdata_out <= {29'h00000000, conv_on_reg, init_reg,
                                      state_reg != H_IDLE && state_reg != H_READY};
          REG_IRQ_STAT: rdata_out <= {30'h00000000, irq_stat_reg};
          REG_IRQ_MASK: rdata_out <= {30'h00000000, irq_mask_reg};
          REG_GAIN:     rdata_out <= {8'h00, gain_reg};
          REG_DATA:     rdata_out <= {8'h00, data_reg};
          default:      rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sclk = sclk_reg;
  assign link.sdi  = sdi_reg;
endmodule
`default_nettype wire

// File: sim/crgi_link_chk.sv
/*
  Checker for the serial link between the two ends.
  Assumes one clock and an asynchronous active-low reset.
*/
`default_nettype none
module crgi_link_chk
  (
    // Clock, reset and link signals.
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sdo_line
  );
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  a_oe_off: assert property (cs_n |=> !sdo_oe) else $error("sdo driven while idle");
  a_oe_on: assert property (!cs_n |=> sdo_oe) else $error("sdo not driven");
  a_idle_high: assert property (!sdo_oe |-> sdo) else $error("output low while off");
  a_sclk_sel: assert property (sclk |-> !cs_n) else $error("clock while unselected");
  a_cs_quiet: assert property ($changed(cs_n) |-> !sclk) else $error("select moved with clock high");
  a_sclk_high: assert property ($rose(sclk) |-> sclk [*8]) else $error("short clock high");
  a_sclk_low: assert property ($fell(sclk) |-> !sclk [*8]) else $error("short clock low");
  a_sdi_hold: assert property (sclk && $past(sclk) |-> $stable(sdi)) else $error("sdi moved");
  a_sdo_hold: assert property (sclk && $past(sclk) && sdo_oe |-> $stable(sdo)) else $error("sdo moved");
endmodule
`default_nettype wire

// File: sim/converter_reset_gain_init_tb.sv
/*
  Bench joining both ends over the link, driven through the register port.
  Assumes a 200 MHz clock and a shortened oscillator wait.
*/
`default_nettype none
module converter_reset_gain_init_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import crgi_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_d = 1'b0;
  logic        sval = 1'b0;
  logic        irq, conv_o, rst_o;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [23:0] smp = 24'h0, g, e, gain_o, data_o;
  logic [47:0] p;
  logic [63:0] eq[$];
  int          miscompares = 0;
  int          n_checks = 0;
  crgi_link_if link();
  always #2.5 clk_sys_in = ~clk_sys_in;
  crgi_dev crgi_dev_inst (.clk_sys_in, .arst_n_in, .link(link), .sample_in(smp), .sample_valid_in(sval),
    .gain_out(gain_o), .data_out(data_o), .converting_out(conv_o), .reset_active_out(rst_o));
  crgi_host #(.OSC_CYC(50)) crgi_host_inst (.clk_sys_in, .arst_n_in, .link(link), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq));
  crgi_link_chk crgi_link_chk_inst (.clk_sys_in, .arst_n_in, .cs_n(link.cs_n), .sclk(link.sclk),
    .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic need(input logic ok);
    if (ok !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] k = 32'hFFFFFFFF);
    @(posedge clk_sys_in);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w)
      eq.push_back({k, d});
    @(posedge clk_sys_in);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Read results are compared against the oldest queued note.
  always @(posedge clk_sys_in)
  begin
    rd_d <= rd;
    if (rd_d)
    begin
      rv = rdata;
      chk(rdata & eq[0][63:32], eq[0][31:0]);
      void'(eq.pop_front());
    end
  end
  task automatic poll(input logic [31:0] k, input logic [31:0] w);
    for (int i = 0; i < 2000; i++)
    begin
      acc(1'b0, REG_STATUS, 32'h0, 32'h0);
      repeat (2) @(posedge clk_sys_in);
      if ((rv & k) === w)
        return;
    end
    need(1'b0);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 30000 && irq !== 1'b1; i++)
      @(posedge clk_sys_in);
    need(irq);
  endtask
  task automatic init_run();
    acc(1'b1, REG_CTRL, 32'h3);
    for (int i = 0; i < 30000 && rst_o !== 1'b1; i++)
      @(posedge clk_sys_in);
    need(rst_o);
    @(posedge clk_sys_in);
    chk({8'h00, gain_o}, {8'h00, GAIN_DEFAULT});
    wait_irq();
    chk({31'h0, rst_o}, 32'h0);
    acc(1'b0, REG_STATUS, 32'h2);
    acc(1'b1, REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, REG_IRQ_MASK, 32'h3);
    acc(1'b0, REG_IRQ_STAT, 32'h1);
    acc(1'b1, REG_IRQ_STAT, 32'h1);
    acc(1'b0, REG_IRQ_STAT, 32'h0);
  endtask
  task automatic gain_set(input logic [23:0] v, input logic [23:0] x);
    acc(1'b1, REG_GAIN, {8'h00, v});
    acc(1'b1, REG_CTRL, 32'h4);
    poll(32'h1, 32'h0);
    chk({8'h00, gain_o}, {8'h00, x});
    acc(1'b0, REG_GAIN, {8'h00, x});
  endtask
  initial
  begin
    void'($urandom(32'h22DEF585));
    repeat (10) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    acc(1'b0, REG_STATUS, 32'h0);
    acc(1'b0, 8'h20, 32'h0);
    acc(1'b1, REG_IRQ_MASK, 32'h3);
    acc(1'b0, REG_IRQ_MASK, 32'h3);
    init_run();
    gain_set(24'h800000, 24'h800000);
    gain_set(24'h100000, GAIN_MIN);
    init_run();
    g = 24'($urandom_range(32'hFFFFFF, 32'h266666));
    gain_set(g, g);
    acc(1'b1, REG_CTRL, 32'h8);
    poll(32'h4, 32'h4);
    chk({31'h0, conv_o}, 32'h1);
    repeat (3)
    begin
      smp <= 24'($urandom);
      sval <= 1'b1;
      @(posedge clk_sys_in);
      sval <= 1'b0;
      p = (48'(smp) * 48'(g)) >> 22;
      e = (p > 48'hFFFFFF) ? 24'hFFFFFF : p[23:0];
      acc(1'b1, REG_CTRL, 32'h10);
      wait_irq();
      acc(1'b0, REG_DATA, {8'h00, e});
      chk({8'h00, data_o}, {8'h00, e});
      acc(1'b1, REG_IRQ_STAT, 32'h2);
    end
    stop_test();
  end
endmodule
`default_nettype wire
